// [hw/dcf_fifo.v]
// Queue with push and pop strobe clocks, loadable almost flags and retransmit
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defs.vh"
// Notes on behaviour
// - Depth is a power of two from 32 to 1024 words, set at build.
// - Word width is a build parameter of at least one bit.
// - Input word is stored at push clock falling edge while push enable is high.
// - Next word appears on read data at pop clock rising edge when pop enabled.
// - Threshold strobe rising edge loads almost-empty (select 0) or almost-full (select 1).
// - Reset sets almost-empty to a quarter, almost-full to three quarters of depth.
// - Write data is as wide as the larger of word width and log2 depth.
// - Empty and almost-empty are active high, updated by the pop clock.
// - Full and almost-full are active high, updated by the push clock.
// - Separate synchronous low resets clear the read and write counters.
// - With fewer writes than depth, pop reset alone rewinds for reread.
// - Pop reset restores the almost-empty threshold to its default.
module dcf_fifo #(
  parameter ADDR_W = `DCF_DEF_ADDR_W,
  parameter DATA_W = `DCF_DEF_DATA_W
) (
  // Clock and reset
  input  wire                       clk,
  input  wire                       sys_rst,
  // Push side
  input  wire                       push_clock,
  input  wire                       push_enable,
  input  wire                       push_side_reset_n,
  input  wire [((DATA_W > ADDR_W) ? DATA_W : ADDR_W)-1:0] write_data_in,
  output reg                        queue_full_flag,
  output reg                        almost_full_flag,
  // Threshold load
  input  wire                       threshold_strobe,
  input  wire                       threshold_select,
  // Pop side
  input  wire                       pop_clock,
  input  wire                       pop_enable,
  input  wire                       pop_side_reset_n,
  output reg  [DATA_W-1:0]          read_data_out,
  output reg                        queue_empty_flag,
  output reg                        almost_empty_flag,
  // Register port
  input  wire [`DCF_REG_ADDR_W-1:0] reg_addr,
  input  wire [`DCF_REG_DATA_W-1:0] reg_wdata,
  input  wire                       reg_write,
  input  wire                       reg_read,
  output reg  [`DCF_REG_DATA_W-1:0] reg_rdata,
  // Interrupt
  output wire                       irq
);
  localparam PTR_W = ADDR_W + 1;
  // Quarters worked out wide, then cut to the threshold width on purpose
  localparam integer AE_QTR = `DCF_AE_QUARTERS << (ADDR_W - 2);
  localparam integer AF_QTR = `DCF_AF_QUARTERS << (ADDR_W - 2);
  localparam [ADDR_W-1:0] AE_DEF = AE_QTR[ADDR_W-1:0];
  localparam [ADDR_W-1:0] AF_DEF = AF_QTR[ADDR_W-1:0];

  function [PTR_W-1:0] bin2gray;
    input [PTR_W-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [PTR_W-1:0] gray2bin;
    input [PTR_W-1:0] g;
    integer i;
    begin
      gray2bin[PTR_W-1] = g[PTR_W-1];
      for (i = PTR_W - 2; i >= 0; i = i - 1)
      begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // Edge detection of the strobe clocks, sampled by clk
  reg                push_clk_q;
  reg                pop_clk_q;
  reg                thr_strobe_q;
  wire               push_rise = push_clock & ~push_clk_q;
  wire               push_fall = ~push_clock & push_clk_q;
  wire               pop_rise  = pop_clock & ~pop_clk_q;
  wire               thr_rise  = threshold_strobe & ~thr_strobe_q;

  reg  [PTR_W-1:0]   wptr;
  reg  [PTR_W-1:0]   rptr;
  reg  [PTR_W-1:0]   wsync1;
  reg  [PTR_W-1:0]   wsync2;
  reg  [PTR_W-1:0]   rsync1;
  reg  [PTR_W-1:0]   rsync2;
  reg  [ADDR_W-1:0]  ae_thr;
  reg  [ADDR_W-1:0]  af_thr;
  reg  [`DCF_EV_W-1:0] ev_status;
  reg  [`DCF_EV_W-1:0] ev_enable;

  wire [PTR_W-1:0]   push_fill = wptr - gray2bin(rsync2);
  wire [PTR_W-1:0]   pop_fill  = gray2bin(wsync2) - rptr;
  wire               push_ok   = push_fall & push_enable & ~queue_full_flag;
  wire               pop_ok    = pop_rise & pop_enable & ~queue_empty_flag;
  wire               push_drop = push_fall & push_enable & queue_full_flag;
  wire               pop_drop  = pop_rise & pop_enable & queue_empty_flag;
  wire [DATA_W-1:0]  store_q;

  reg  [PTR_W-1:0]   next_rptr;
  reg  [PTR_W-1:0]   next_pop_fill;

  dcf_store #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_store (
    .clk     (clk),
    .wr_en   (push_ok),
    .wr_addr (wptr[ADDR_W-1:0]),
    .wr_data (write_data_in[DATA_W-1:0]),
    .rd_addr (rptr[ADDR_W-1:0]),
    .rd_data (store_q)
  );

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      push_clk_q   <= 1'b0;
      pop_clk_q    <= 1'b0;
      thr_strobe_q <= 1'b0;
    end
    else
    begin
      push_clk_q   <= push_clock;
      pop_clk_q    <= pop_clock;
      thr_strobe_q <= threshold_strobe;
    end
  end

  // Push side: write pointer, full flags, read pointer crossing
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wptr             <= {PTR_W{1'b0}};
      rsync1           <= {PTR_W{1'b0}};
      rsync2           <= {PTR_W{1'b0}};
      queue_full_flag  <= 1'b0;
      almost_full_flag <= 1'b0;
    end
    else
    begin
      if (push_rise)
      begin
        rsync1 <= bin2gray(rptr);
        rsync2 <= rsync1;
        if (!push_side_reset_n)
        begin
          wptr             <= {PTR_W{1'b0}};
          queue_full_flag  <= 1'b0;
          almost_full_flag <= 1'b0;
        end
        else
        begin
          queue_full_flag  <= push_fill[ADDR_W];
          almost_full_flag <= push_fill >= {1'b0, af_thr};
        end
      end
      else if (push_ok)
      begin
        wptr <= wptr + 1'b1;
      end
    end
  end

  always @*
  begin
    next_rptr = rptr;
    if (!pop_side_reset_n)
    begin
      next_rptr = {PTR_W{1'b0}};
    end
    else if (pop_ok)
    begin
      next_rptr = rptr + 1'b1;
    end
    next_pop_fill = gray2bin(wsync2) - next_rptr;
  end

  // Pop side: read pointer, output word, empty flags, write pointer crossing
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rptr              <= {PTR_W{1'b0}};
      wsync1            <= {PTR_W{1'b0}};
      wsync2            <= {PTR_W{1'b0}};
      read_data_out     <= {DATA_W{1'b0}};
      queue_empty_flag  <= 1'b1;
      almost_empty_flag <= 1'b1;
    end
    else if (pop_rise)
    begin
      wsync1            <= bin2gray(wptr);
      wsync2            <= wsync1;
      rptr              <= next_rptr;
      queue_empty_flag  <= next_pop_fill == {PTR_W{1'b0}};
      almost_empty_flag <= next_pop_fill <= {1'b0, ae_thr};
      if (pop_side_reset_n && pop_ok)
      begin
        read_data_out <= store_q;
      end
    end
  end

  // Thresholds; a side reset beats a load arriving with it
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ae_thr <= AE_DEF;
      af_thr <= AF_DEF;
    end
    else
    begin
      if (pop_rise && !pop_side_reset_n)
      begin
        ae_thr <= AE_DEF;
      end
      else if (thr_rise && !threshold_select)
      begin
        ae_thr <= write_data_in[ADDR_W-1:0];
      end
      if (push_rise && !push_side_reset_n)
      begin
        af_thr <= AF_DEF;
      end
      else if (thr_rise && threshold_select)
      begin
        af_thr <= write_data_in[ADDR_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  reg  [`DCF_EV_W-1:0] ev_set;
  reg  [`DCF_EV_W-1:0] ev_clr;
  reg                  full_q;
  reg                  empty_q;
  reg                  afull_q;
  reg                  aempty_q;

  always @*
  begin
    ev_set = `DCF_EV_RESET;
    ev_set[`DCF_EV_PUSH_DROP] = push_drop;
    ev_set[`DCF_EV_POP_DROP]  = pop_drop;
    ev_set[`DCF_EV_FULL]      = queue_full_flag & ~full_q;
    ev_set[`DCF_EV_EMPTY]     = queue_empty_flag & ~empty_q;
    ev_set[`DCF_EV_AFULL]     = almost_full_flag & ~afull_q;
    ev_set[`DCF_EV_AEMPTY]    = almost_empty_flag & ~aempty_q;
    ev_clr = `DCF_EV_RESET;
    if (reg_write && reg_addr == `DCF_REG_IRQ_CLEAR)
    begin
      ev_clr = reg_wdata[`DCF_EV_W-1:0];
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      full_q    <= 1'b0;
      empty_q   <= 1'b1;
      afull_q   <= 1'b0;
      aempty_q  <= 1'b1;
      ev_status <= `DCF_EV_RESET;
      ev_enable <= `DCF_EV_RESET;
    end
    else
    begin
      full_q    <= queue_full_flag;
      empty_q   <= queue_empty_flag;
      afull_q   <= almost_full_flag;
      aempty_q  <= almost_empty_flag;
      ev_status <= (ev_status & ~ev_clr) | ev_set;
      if (reg_write && reg_addr == `DCF_REG_IRQ_ENABLE)
      begin
        ev_enable <= reg_wdata[`DCF_EV_W-1:0];
      end
    end
  end

  assign irq = |(ev_status & ev_enable);

  // Read data stands one cycle after the read strobe only
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= {`DCF_REG_DATA_W{1'b0}};
    end
    else
    begin
      reg_rdata <= {`DCF_REG_DATA_W{1'b0}};
      if (reg_read)
      begin
        case (reg_addr)
          `DCF_REG_STATUS:
            reg_rdata[`DCF_EV_W-1:0] <= ev_status;
          `DCF_REG_IRQ_ENABLE:
            reg_rdata[`DCF_EV_W-1:0] <= ev_enable;
          `DCF_REG_LEVELS:
          begin
            reg_rdata[`DCF_LV_PUSH_FILL +: PTR_W] <= push_fill;
            reg_rdata[`DCF_LV_POP_FILL +: PTR_W]  <= pop_fill;
          end
          default:
            reg_rdata <= {`DCF_REG_DATA_W{1'b0}};
        endcase
      end
    end
  end
endmodule // dcf_fifo
`default_nettype wire

// [hw/dcf_defs.vh]
// Constants shared by the programmable-flag queue and its storage
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

// Default build sizes
`define DCF_DEF_ADDR_W     5
`define DCF_DEF_DATA_W     8
`define DCF_MIN_ADDR_W     5
`define DCF_MAX_ADDR_W     10

// Register bus
`define DCF_REG_ADDR_W     4
`define DCF_REG_DATA_W     32
`define DCF_REG_STATUS     4'h0
`define DCF_REG_IRQ_CLEAR  4'h1
`define DCF_REG_IRQ_ENABLE 4'h2
`define DCF_REG_LEVELS     4'h3

// Event bit positions in status, clear and enable
`define DCF_EV_W           6
`define DCF_EV_PUSH_DROP   0
`define DCF_EV_POP_DROP    1
`define DCF_EV_FULL        2
`define DCF_EV_EMPTY       3
`define DCF_EV_AFULL       4
`define DCF_EV_AEMPTY      5
`define DCF_EV_RESET       6'h00

// Field positions of the levels register
`define DCF_LV_PUSH_FILL   0
`define DCF_LV_POP_FILL    16

// Threshold defaults as quarters of the depth
`define DCF_AE_QUARTERS    1
`define DCF_AF_QUARTERS    3

`endif

// [hw/dcf_store.v]
// Flip-flop word storage with one write port and one combinational read port
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defs.vh"
module dcf_store #(
  parameter ADDR_W = `DCF_DEF_ADDR_W,
  parameter DATA_W = `DCF_DEF_DATA_W
) (
  // Clock
  input  wire              clk,
  // Write port
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  // Read port
  input  wire [ADDR_W-1:0] rd_addr,
  output wire [DATA_W-1:0] rd_data
);
  reg [DATA_W-1:0] words [0:(1<<ADDR_W)-1];

  // No reset: contents are undefined until written, like a RAM
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      words[wr_addr] <= wr_data;
    end
  end

  assign rd_data = words[rd_addr];
endmodule // dcf_store
`default_nettype wire

// [hw/dcf_end.v]
// Restores implicit nets once the design sources are read
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/dcf_clk_model.sv]
// Producer and consumer strobe clocks for the queue, derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module dcf_clk_model #(
  parameter PUSH_HALF = 3,
  parameter POP_HALF  = 2
) (
  // System clock and pace control
  input  wire logic clk,
  input  wire logic slow,
  // Strobe clocks
  output wire logic push_clock,
  output wire logic pop_clock
);
  int push_cnt = 0;
  int push_ph  = 0;
  int pop_cnt  = 0;
  int pop_ph   = 0;
  assign push_clock = push_ph[0];
  assign pop_clock  = pop_ph[0];
  // Runs through every reset, so side resets always meet a rising edge
  always @(posedge clk)
  begin
    if (push_cnt >= PUSH_HALF - 1)
    begin
      push_cnt <= 0;
      push_ph  <= push_ph + 1;
    end
    else
      push_cnt <= push_cnt + 1;
    if (pop_cnt >= (slow ? 5 : POP_HALF - 1))
    begin
      pop_cnt <= 0;
      pop_ph  <= pop_ph + 1;
    end
    else
      pop_cnt <= pop_cnt + 1;
  end
endmodule // dcf_clk_model
`default_nettype wire

// [bench/dcf_fifo_sva.sv]
// Concurrent checks on the queue's flags, read data and register port
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_sva #(
  parameter DATA_W = 8
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              push_clock,
  input wire logic              pop_clock,
  input wire logic              pop_enable,
  input wire logic              queue_full_flag,
  input wire logic              almost_full_flag,
  input wire logic              queue_empty_flag,
  input wire logic              almost_empty_flag,
  input wire logic [DATA_W-1:0] read_data_out,
  input wire logic              reg_read,
  input wire logic [31:0]       reg_rdata,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence pop_try_s(e);
    (e && !pop_clock) ##1 (pop_clock && pop_enable);
  endsequence
  rst_flags_a: assert property (disable iff (1'b0) sys_rst |=>
    queue_empty_flag && almost_empty_flag && !queue_full_flag && !almost_full_flag && !irq)
    else $error("flags not at reset values");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  full_sync_a: assert property ($changed(queue_full_flag) && !$past(sys_rst) |->
    $past(push_clock) || $past(push_clock, 2)) else $error("full flag off push clock");
  empty_sync_a: assert property ($changed(queue_empty_flag) && !$past(sys_rst) |->
    $past(pop_clock) || $past(pop_clock, 2)) else $error("empty flag off pop clock");
  data_sync_a: assert property ($changed(read_data_out) && !$past(sys_rst) |->
    $past(pop_enable) && $past(pop_clock) && !$past(pop_clock, 2))
    else $error("read data moved without a pop");
  drop_stable_a: assert property (pop_try_s(queue_empty_flag) |=>
    $stable(read_data_out)) else $error("pop on empty changed data");
  empty_ae_a: assert property (queue_empty_flag |-> almost_empty_flag)
    else $error("empty without almost empty");
  full_af_a: assert property (queue_full_flag |-> almost_full_flag)
    else $error("full without almost full");
endmodule // dcf_fifo_sva
bind dcf_fifo dcf_fifo_sva #(.DATA_W(DATA_W)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .push_clock(push_clock), .pop_clock(pop_clock),
  .pop_enable(pop_enable), .queue_full_flag(queue_full_flag),
  .almost_full_flag(almost_full_flag), .queue_empty_flag(queue_empty_flag),
  .almost_empty_flag(almost_empty_flag), .read_data_out(read_data_out),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// [bench/tb_dual_clock_fifo_prog_flags.sv]
// Self-checking bench for the queue with loadable almost flags
`timescale 1ns/1ps
`default_nettype none
module tb_dual_clock_fifo_prog_flags;
  localparam DEPTH = 32;
  logic clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, push_clock, pop_clock;
  logic push_enable = 1'b0, pop_enable = 1'b0, push_side_reset_n = 1'b1;
  logic pop_side_reset_n = 1'b1, threshold_strobe = 1'b0, threshold_select = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, irq;
  logic queue_full_flag, almost_full_flag, queue_empty_flag, almost_empty_flag;
  logic [7:0]  write_data_in = 8'h00;
  logic [7:0]  read_data_out;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [7:0]  exp_q[$];
  logic [7:0]  saved[$];
  int n_fail = 0, n_compared = 0, cyc = 0, seed;

  dcf_clk_model u_clk (.clk(clk), .slow(slow), .push_clock(push_clock), .pop_clock(pop_clock));
  dcf_fifo #(.ADDR_W(5), .DATA_W(8)) uut (
    .clk(clk), .sys_rst(sys_rst), .push_clock(push_clock), .push_enable(push_enable),
    .push_side_reset_n(push_side_reset_n), .write_data_in(write_data_in),
    .queue_full_flag(queue_full_flag), .almost_full_flag(almost_full_flag),
    .threshold_strobe(threshold_strobe), .threshold_select(threshold_select),
    .pop_clock(pop_clock), .pop_enable(pop_enable), .pop_side_reset_n(pop_side_reset_n),
    .read_data_out(read_data_out), .queue_empty_flag(queue_empty_flag),
    .almost_empty_flag(almost_empty_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

  initial forever #2 clk = ~clk;

  function automatic logic ae_exp(input int fill, input int thr_v);
    return fill <= thr_v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // Returns at the first edge on which the chosen strobe clock reads v after having read the other level
  task automatic wait_clk(input bit pop, input logic v);
    do @(posedge clk); while ((pop ? pop_clock : push_clock) === v);
    do @(posedge clk); while ((pop ? pop_clock : push_clock) !== v);
  endtask

  task automatic push_n(input int n, input int keep);
    wait_clk(0, 1'b0);
    push_enable <= 1'b1;
    write_data_in <= 8'($urandom);
    for (int i = 0; i < n; i++)
    begin
      wait_clk(0, 1'b0);
      if (i < keep) exp_q.push_back(write_data_in);
      write_data_in <= 8'($urandom);
    end
    push_enable <= 1'b0;
  endtask

  task automatic pop_n(input int n);
    wait_clk(1, 1'b0);
    pop_enable <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      wait_clk(1, 1'b1);
      #1;
      if (exp_q.size() > 0) chk(read_data_out, exp_q.pop_front());
    end
    wait_clk(1, 1'b0);
    pop_enable <= 1'b0;
  endtask

  task automatic thr(input logic sel, input logic [7:0] v);
    @(posedge clk);
    threshold_select <= sel;
    write_data_in <= v;
    threshold_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    threshold_strobe <= 1'b0;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial
  begin
    seed = $urandom(25);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Loaded thresholds, partial fill, then rewind and read again
    thr(1'b1, 8'h05);
    thr(1'b0, 8'h0C);
    push_n(10, 10);
    repeat (60) @(posedge clk);
    chk(almost_full_flag, 1'b1);
    chk(almost_empty_flag, ae_exp(10, 12));
    saved = exp_q;
    pop_n(10);
    wait_clk(1, 1'b0);
    pop_side_reset_n <= 1'b0;
    wait_clk(1, 1'b1);
    wait_clk(1, 1'b0);
    pop_side_reset_n <= 1'b1;
    exp_q = saved;
    repeat (20) @(posedge clk);
    chk(almost_empty_flag, ae_exp(10, DEPTH / 4));
    pop_n(10);
    repeat (30) @(posedge clk);
    chk(queue_empty_flag, 1'b1);
    // Overfill by one, drain slowly past empty, then interrupt handling
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    slow <= 1'b1;
    push_n(DEPTH + 1, DEPTH);
    repeat (60) @(posedge clk);
    chk(queue_full_flag, 1'b1);
    chk(irq, 1'b0);
    reg_rd(4'h3, 32'h0020_0020);
    pop_n(DEPTH);
    pop_n(1);
    repeat (60) @(posedge clk);
    chk(queue_empty_flag, 1'b1);
    reg_rd(4'h0, 32'h0000_003F);
    reg_wr(4'h2, 32'h0000_0003);
    chk(irq, 1'b1);
    reg_rd(4'h2, 32'h0000_0003);
    reg_wr(4'h1, 32'h0000_003F);
    chk(irq, 1'b0);
    reg_rd(4'h0, 32'h0000_0000);
    reg_rd(4'hF, 32'h0000_0000);
    // Both side resets as a general reset; push side held until the read copy settles
    push_side_reset_n <= 1'b0;
    pop_side_reset_n <= 1'b0;
    wait_clk(1, 1'b1);
    pop_side_reset_n <= 1'b1;
    repeat (2) wait_clk(0, 1'b1);
    push_side_reset_n <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    chk(queue_full_flag, 1'b0);
    chk(queue_empty_flag, 1'b1);
    reg_rd(4'h3, 32'h0000_0000);
    push_n(3, 3);
    repeat (60) @(posedge clk);
    pop_n(3);
    tally_and_finish();
  end
endmodule // tb_dual_clock_fifo_prog_flags
`default_nettype wire
